// file: shared/odcr_defs.svh
/*
 Constants of the output driver configuration and readback block.
 Assumes the serial frame layout below and MSB-first shifting.
*/
`ifndef ODCR_DEFS_SVH
`define ODCR_DEFS_SVH
`define ODCR_CNT_W         5
`define ODCR_WORD_W        16
`define ODCR_SHIFT_W       24
`define ODCR_CRC_W         8
`define ODCR_FRAME_PLAIN   5'h10
`define ODCR_FRAME_CHECKED 5'h18
`define ODCR_READ_DECIDE   5'h04
`define ODCR_READ_FIRST    5'h05
`define ODCR_CNT_MAX       5'h1f
`define ODCR_CRC_POLY      8'h07
`define ODCR_CRC_INIT      8'h00
`define ODCR_F_ADDR        15:13
`define ODCR_F_RW          12
`define ODCR_F_SWCLR       11
`define ODCR_F_RANGE       10:7
`define ODCR_F_CLEAR_LEVEL_SELECT      6
`define ODCR_F_OUTPUT_DRIVE_ENABLE       5
`define ODCR_F_SENSE_RESISTOR_SELECT        4
`define ODCR_F_RESET       3
`define ODCR_F_CHECK       7:0
`define ODCR_F_CHK_WORD    23:8
`define ODCR_F_PLN_WORD    15:0
`define ODCR_ST_PEC        3
`define ODCR_ST_OT         2
`define ODCR_ST_CURRENT_OUTPUT_PIN       1
`define ODCR_ST_VOLTAGE_OUTPUT_PIN       0
`define ODCR_RB_FIXED      2'h2
`define ODCR_RST_RANGE     4'h0
`define ODCR_RST_BIT       1'h0
`endif

// file: shared/odcr_pkg.sv
/*
 Types of the output driver configuration and readback block.
 Assumes the constants header is compiled alongside.
*/
package odcr_pkg;
	typedef enum logic [2:0] {
		LINK_IDLE  = 3'h1,
		LINK_WRITE = 3'h2,
		LINK_READ  = 3'h4
	} odcr_link_type;

	// Value is {resistor select, range code}
	typedef enum logic [4:0] {
		RNG_I4_20_EXT  = 5'h00,
		RNG_I0_20_EXT  = 5'h01,
		RNG_I0_24_EXT  = 5'h02,
		RNG_V0_5_EXT   = 5'h05,
		RNG_V0_10_EXT  = 5'h06,
		RNG_V0_6_EXT   = 5'h09,
		RNG_V0_12_EXT  = 5'h0a,
		RNG_V0_40_EXT  = 5'h0e,
		RNG_V0_44_EXT  = 5'h0f,
		RNG_I4_20_INT  = 5'h10,
		RNG_I0_20_INT  = 5'h11,
		RNG_I0_24_INT  = 5'h12,
		RNG_V0_5_INT   = 5'h15,
		RNG_V0_10_INT  = 5'h16,
		RNG_V0_6_INT   = 5'h19,
		RNG_V0_12_INT  = 5'h1a,
		RNG_I3_20_OVR  = 5'h1d,
		RNG_I0_20_OVR  = 5'h1e,
		RNG_I0_24_OVR  = 5'h1f
	} odcr_range_type;
endpackage : odcr_pkg

// file: verilog/odcr_sync.sv
/*
 Two-stage synchroniser for a vector of unrelated levels.
 Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/1ps
`default_nettype none
module odcr_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	// Levels
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} odcr_sync_type;

	odcr_sync_type s;
	odcr_sync_type next_s;

	// First stage feeds only the second stage
	always_comb begin
		next_s.meta   = i_async;
		next_s.stable = s.meta;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_sync = s.stable;
endmodule : odcr_sync
`default_nettype wire

// file: verilog/odcr_top.sv
/*
 Configuration register, serial link and readback of a single-channel
 voltage/current output driver, with hardware pin mode and fault pins.
 Assumes all pins are asynchronous to i_clock and the serial clock is
 several times slower than i_clock; open-drain wires are resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "odcr_defs.svh"
module odcr_top (
	// Clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_rst,
	// Serial link
	input  wire logic                   i_sclk,
	input  wire logic                   i_sync_n,
	input  wire logic                   i_sdin,
	output logic                        o_sdo,
	output logic                        o_sdo_oe,
	// Board straps and control pins
	input  wire logic [2:0]             i_board_address_pins,
	input  wire logic                   i_control_mode_pin,
	input  wire logic [3:0]             i_range_pins,
	input  wire logic                   i_sense_resistor_select_pin,
	input  wire logic                   i_clear_level_select_pin,
	input  wire logic                   i_clear_pin,
	// Analog fault detectors
	input  wire logic                   i_open_circuit,
	input  wire logic                   i_short_circuit,
	input  wire logic                   i_over_temp,
	// Output stage control
	output odcr_pkg::odcr_range_type    o_range,
	output logic                        o_range_valid,
	output logic                        o_current_drive_en,
	output logic                        o_voltage_drive_en,
	output logic                        o_clear_active,
	output logic                        o_clear_to_midscale,
	// Open-drain fault pins
	output logic                        o_fault_n,
	output logic                        o_fault_n_oe,
	output logic                        o_current_loop_fault_n,
	output logic                        o_current_loop_fault_n_oe,
	output logic                        o_voltage_short_fault_n,
	output logic                        o_voltage_short_fault_n_oe,
	output logic                        o_temp_fault_n,
	output logic                        o_temp_fault_n_oe
);
	import odcr_pkg::*;

	typedef struct packed {
		odcr_link_type                link;
		logic                         sclk_q;
		logic                         sync_q;
		logic [`ODCR_CNT_W-1:0]       bits;
		logic [`ODCR_CNT_W-1:0]       rises;
		logic [`ODCR_SHIFT_W-1:0]     shreg;
		logic [`ODCR_WORD_W-1:0]      rdword;
		logic [3:0]                   range;
		logic                         clear_level_select;
		logic                         output_drive_enable;
		logic                         sense_resistor_select;
		logic                         swclr;
		logic                         frame_check;
		logic [3:0]                   status;
		logic                         hw;
		odcr_range_type               range_out;
		logic                         range_valid;
		logic                         cur_en;
		logic                         volt_en;
		logic                         clr_act;
		logic                         clr_mid;
		logic                         sdo;
		logic                         sdo_oe;
		logic                         fault_oe;
		logic                         current_loop_fault_n_oe;
		logic                         voltage_short_fault_n_oe;
		logic                         tfault_oe;
		logic                         od_level;
	} odcr_state_type;

	odcr_state_type               s;
	odcr_state_type               next_s;
	logic                         sclk_s;
	logic                         sync_s;
	logic                         sdin_s;
	logic [2:0]                   addr_s;
	logic                         mode_s;
	logic [3:0]                   rpins_s;
	logic                         sense_resistor_select_s;
	logic                         clear_level_select_s;
	logic                         clear_s;
	logic                         oc_s;
	logic                         sc_s;
	logic                         ot_s;
	logic                         sclk_rise;
	logic                         sclk_fall;
	logic                         sync_rise;
	logic                         checked;
	logic                         frame_ok;
	logic [`ODCR_WORD_W-1:0]      word;
	logic                         crc_ok;
	logic                         apply;
	logic                         pec_set;
	logic                         pec_clr;
	logic                         rd_msb;
	logic [4:0]                   eff_code;

	// Synchronisers
	odcr_sync #(.WIDTH(3)) u_link_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async ({i_sclk, i_sync_n, i_sdin}),
		.o_sync  ({sclk_s, sync_s, sdin_s})
	);

	odcr_sync #(.WIDTH(11)) u_pin_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async ({i_board_address_pins, i_control_mode_pin, i_range_pins,
			i_sense_resistor_select_pin, i_clear_level_select_pin, i_clear_pin}),
		.o_sync  ({addr_s, mode_s, rpins_s, sense_resistor_select_s, clear_level_select_s, clear_s})
	);

	odcr_sync #(.WIDTH(3)) u_fault_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async ({i_open_circuit, i_short_circuit, i_over_temp}),
		.o_sync  ({oc_s, sc_s, ot_s})
	);

	function automatic logic [`ODCR_CRC_W-1:0] crc8(input logic [`ODCR_WORD_W-1:0] d);
		logic [`ODCR_CRC_W-1:0] c;
		c = `ODCR_CRC_INIT;
		for (int k = `ODCR_WORD_W - 1; k >= 0; k--) begin
			if (c[`ODCR_CRC_W-1] ^ d[k]) begin
				c = (c << 1) ^ `ODCR_CRC_POLY;
			end else begin
				c = c << 1;
			end
		end
		return c;
	endfunction : crc8

	// Unused codes still reach o_range, but with o_range_valid and both drive enables low
	function automatic logic code_valid(input logic [4:0] code);
		case (code)
			RNG_I4_20_EXT, RNG_I0_20_EXT, RNG_I0_24_EXT,
			RNG_I4_20_INT, RNG_I0_20_INT, RNG_I0_24_INT,
			RNG_I3_20_OVR, RNG_I0_20_OVR, RNG_I0_24_OVR,
			RNG_V0_5_EXT, RNG_V0_10_EXT, RNG_V0_40_EXT, RNG_V0_44_EXT,
			RNG_V0_5_INT, RNG_V0_10_INT,
			RNG_V0_6_EXT, RNG_V0_12_EXT, RNG_V0_6_INT, RNG_V0_12_INT: code_valid = 1'h1;
			default: code_valid = 1'h0;
		endcase
	endfunction : code_valid

	function automatic logic code_current(input logic [4:0] code);
		case (code)
			RNG_I4_20_EXT, RNG_I0_20_EXT, RNG_I0_24_EXT,
			RNG_I4_20_INT, RNG_I0_20_INT, RNG_I0_24_INT,
			RNG_I3_20_OVR, RNG_I0_20_OVR, RNG_I0_24_OVR: code_current = 1'h1;
			default: code_current = 1'h0;
		endcase
	endfunction : code_current

	assign sclk_rise = sclk_s & ~s.sclk_q;
	assign sclk_fall = ~sclk_s & s.sclk_q;
	assign sync_rise = sync_s & ~s.sync_q;
	assign rd_msb    = s.rdword[`ODCR_WORD_W-1];
	assign checked   = (s.bits == `ODCR_FRAME_CHECKED);
	assign frame_ok  = checked || (s.bits == `ODCR_FRAME_PLAIN);
	assign word      = checked ? s.shreg[`ODCR_F_CHK_WORD] : s.shreg[`ODCR_F_PLN_WORD];
	assign crc_ok    = !checked || (crc8(word) == s.shreg[`ODCR_F_CHECK]);
	assign pec_set   = (s.link == LINK_WRITE) && sync_rise && frame_ok && !crc_ok
		&& !s.hw;
	// Address compared with strapped pins; reads ignore writes
	assign apply     = (s.link == LINK_WRITE) && sync_rise && frame_ok && crc_ok && !s.hw
		&& (word[`ODCR_F_ADDR] == addr_s) && !word[`ODCR_F_RW];
	assign pec_clr   = ((s.link == LINK_READ) && sync_rise) || (apply && word[`ODCR_F_RESET]);
	// Resistor select is the code's top bit in either mode
	assign eff_code  = s.hw ? {sense_resistor_select_s, rpins_s} : {s.sense_resistor_select, s.range};

	always_comb begin
		next_s        = s;
		next_s.sclk_q = sclk_s;
		next_s.sync_q = sync_s;
		next_s.hw     = mode_s;
		// Set wins over the clear when both land together
		next_s.frame_check    = pec_set | (s.frame_check & ~pec_clr);
		next_s.status = {s.frame_check, ot_s, oc_s, sc_s};
		case (s.link)
			LINK_IDLE: begin
				if (!sync_s && s.sync_q) begin
					next_s.link  = LINK_WRITE;
					next_s.bits  = '0;
					next_s.rises = '0;
				end
			end
			LINK_WRITE: begin
				if (sync_rise) begin
					next_s.link = LINK_IDLE;
				end else begin
					if (sclk_rise && s.rises != `ODCR_CNT_MAX) begin
						next_s.rises = s.rises + 5'h01;
					end
					if (sclk_fall) begin
						next_s.shreg = {s.shreg[`ODCR_SHIFT_W-2:0], sdin_s};
						if (s.bits != `ODCR_CNT_MAX) begin
							next_s.bits = s.bits + 5'h01;
						end
						// Fourth bit received decides a read
						if (s.bits == `ODCR_READ_DECIDE - 5'h01 && !s.hw && sdin_s
							&& s.shreg[2:0] == addr_s) begin
							next_s.link   = LINK_READ;
							next_s.sdo_oe = 1'h1;
							// Status and configuration in one word
							next_s.rdword = {addr_s, `ODCR_RB_FIXED, s.range, s.clear_level_select,
								s.output_drive_enable, s.sense_resistor_select, s.status};
						end
					end
				end
			end
			LINK_READ: begin
				if (sync_rise) begin
					next_s.link   = LINK_IDLE;
					next_s.sdo_oe = 1'h0;
				end else if (sclk_rise && s.rises != `ODCR_CNT_MAX) begin
					next_s.rises = s.rises + 5'h01;
					if (s.rises >= `ODCR_READ_FIRST - 5'h01) begin
						next_s.sdo    = rd_msb;
						next_s.rdword = s.rdword << 1;
					end
				end
			end
			default: begin
				next_s.link   = LINK_IDLE;
				next_s.sdo_oe = 1'h0;
			end
		endcase
		if (apply) begin
			if (word[`ODCR_F_RESET]) begin
				// Back to power-on configuration
				next_s.range  = `ODCR_RST_RANGE;
				next_s.clear_level_select = `ODCR_RST_BIT;
				next_s.output_drive_enable  = `ODCR_RST_BIT;
				next_s.sense_resistor_select   = `ODCR_RST_BIT;
				next_s.swclr  = `ODCR_RST_BIT;
			end else begin
				next_s.range  = word[`ODCR_F_RANGE];
				next_s.clear_level_select = word[`ODCR_F_CLEAR_LEVEL_SELECT];
				next_s.output_drive_enable  = word[`ODCR_F_OUTPUT_DRIVE_ENABLE];
				next_s.sense_resistor_select   = word[`ODCR_F_SENSE_RESISTOR_SELECT];
				next_s.swclr  = word[`ODCR_F_SWCLR];
			end
		end
		next_s.range_out   = odcr_range_type'(eff_code);
		next_s.range_valid = code_valid(eff_code);
		// Pin mode has no enable bit, so it drives whenever the range is legal
		next_s.cur_en      = code_valid(eff_code) && (s.hw || s.output_drive_enable)
			&& code_current(eff_code);
		next_s.volt_en     = code_valid(eff_code) && (s.hw || s.output_drive_enable)
			&& !code_current(eff_code);
		next_s.clr_act     = clear_s | (~s.hw & s.swclr);
		next_s.clr_mid     = clear_level_select_s | (~s.hw & s.clear_level_select);
		next_s.fault_oe    = ~s.hw & (|s.status);
		next_s.current_loop_fault_n_oe   = s.hw & s.status[`ODCR_ST_CURRENT_OUTPUT_PIN];
		next_s.voltage_short_fault_n_oe   = s.hw & s.status[`ODCR_ST_VOLTAGE_OUTPUT_PIN];
		next_s.tfault_oe   = s.hw & s.status[`ODCR_ST_OT];
		next_s.od_level    = 1'h0;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s        <= '0;
			s.link   <= LINK_IDLE;
			s.sclk_q <= 1'h0;
			s.sync_q <= 1'h0;
			s.range  <= `ODCR_RST_RANGE;
		end else begin
			s <= next_s;
		end
	end

	assign o_sdo                      = s.sdo;
	assign o_sdo_oe                   = s.sdo_oe;
	assign o_range                    = s.range_out;
	assign o_range_valid              = s.range_valid;
	assign o_current_drive_en         = s.cur_en;
	assign o_voltage_drive_en         = s.volt_en;
	assign o_clear_active             = s.clr_act;
	assign o_clear_to_midscale        = s.clr_mid;
	assign o_fault_n                  = s.od_level;
	assign o_fault_n_oe               = s.fault_oe;
	assign o_current_loop_fault_n     = s.od_level;
	assign o_current_loop_fault_n_oe  = s.current_loop_fault_n_oe;
	assign o_voltage_short_fault_n    = s.od_level;
	assign o_voltage_short_fault_n_oe = s.voltage_short_fault_n_oe;
	assign o_temp_fault_n             = s.od_level;
	assign o_temp_fault_n_oe          = s.tfault_oe;

	property p_sdo_enable;
		@(posedge i_clock) disable iff (i_rst)
		$rose(o_sdo_oe) |-> s.link == LINK_READ && $past(s.bits) == `ODCR_READ_DECIDE - 5'h01;
	endproperty
	a_sdo_enable: assert property (p_sdo_enable) else $error("data out enabled off a read");

	property p_first_bit;
		@(posedge i_clock) disable iff (i_rst)
		s.link == LINK_READ && sclk_rise && !sync_rise && s.rises == `ODCR_READ_FIRST - 5'h01
			|=> o_sdo == $past(rd_msb);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first read bit not on 5th rise");

	property p_sdo_release;
		@(posedge i_clock) disable iff (i_rst)
		s.link == LINK_READ && sync_rise |=> !o_sdo_oe ##1 !o_sdo_oe;
	endproperty
	a_sdo_release: assert property (p_sdo_release) else $error("data out not released");

	property p_pec_set;
		@(posedge i_clock) disable iff (i_rst)
		pec_set |=> s.frame_check ##1 s.status[`ODCR_ST_PEC] ##1 o_fault_n_oe;
	endproperty
	a_pec_set: assert property (p_pec_set) else $error("check failure not flagged");

	property p_pec_clear;
		@(posedge i_clock) disable iff (i_rst)
		s.link == LINK_READ && sync_rise |=> !s.frame_check;
	endproperty
	a_pec_clear: assert property (p_pec_clear) else $error("read did not clear error");

	property p_fault_pin;
		@(posedge i_clock) disable iff (i_rst)
		!s.hw && (|s.status) |=> o_fault_n_oe && !o_fault_n;
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("fault pin not pulled low");

	property p_hw_pins;
		@(posedge i_clock) disable iff (i_rst)
		s.hw && s.status[`ODCR_ST_OT] |=> o_temp_fault_n_oe && !o_fault_n_oe;
	endproperty
	a_hw_pins: assert property (p_hw_pins) else $error("pin mode fault routing wrong");

	property p_drive_gate;
		@(posedge i_clock) disable iff (i_rst)
		o_current_drive_en || o_voltage_drive_en |-> $past(s.hw) || $past(s.output_drive_enable);
	endproperty
	a_drive_gate: assert property (p_drive_gate) else $error("output driven while disabled");

	property p_clear_or;
		@(posedge i_clock) disable iff (i_rst)
		clear_level_select_s || (s.clear_level_select && !s.hw) |=> o_clear_to_midscale;
	endproperty
	a_clear_or: assert property (p_clear_or) else $error("clear level not pin OR bit");

	property p_addr_filter;
		@(posedge i_clock) disable iff (i_rst)
		sync_rise && word[`ODCR_F_ADDR] != addr_s |=> $stable(s.range) && $stable(s.output_drive_enable);
	endproperty
	a_addr_filter: assert property (p_addr_filter) else $error("foreign frame changed setup");

	property p_reset_bit;
		@(posedge i_clock) disable iff (i_rst)
		apply && word[`ODCR_F_RESET] |=> s.range == `ODCR_RST_RANGE && !s.output_drive_enable && !s.frame_check;
	endproperty
	a_reset_bit: assert property (p_reset_bit) else $error("reset bit left state");
endmodule : odcr_top
`default_nettype wire

// file: testbench/odcr_ctrl_model.sv
/*
 Behavioural system controller on the serial link of the output driver.
 Assumes the link clock is a quarter of the rate allowed by the design.
*/
`timescale 1ns/1ps
`default_nettype none
module odcr_ctrl_model (
	// Clock
	input  wire logic i_clock,
	// Serial link
	output logic      o_sclk,
	output logic      o_sync_n,
	output logic      o_sdin,
	input  wire logic i_sdo,
	input  wire logic i_sdo_oe
);
	initial begin
		o_sclk   = 1'b0;
		o_sync_n = 1'b1;
		o_sdin   = 1'b0;
	end

	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			fb = c[7] ^ w[i];
			c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
		end
		return c;
	endfunction : crc8

	// Half a link clock period is four system clocks
	task automatic half();
		repeat (4) @(negedge i_clock);
	endtask : half

	// Readback bits are sampled just before the next rise, long after they settle
	task automatic xfer(input logic [15:0] w, input int n, input logic chk, input logic bad,
		output logic [15:0] rb, output logic oe);
		logic [23:0] f;
		f        = {w, chk ? crc8(w) ^ {7'h00, bad} : 8'h00};
		rb       = 16'h0000;
		oe       = 1'b1;
		o_sync_n = 1'b0;
		half();
		for (int i = 0; i < n; i++) begin
			if (i >= 5) begin
				rb = {rb[14:0], i_sdo};
				oe = oe & i_sdo_oe;
			end
			o_sdin = f[23-i];
			o_sclk = 1'b1;
			half();
			o_sclk = 1'b0;
			half();
		end
		rb       = {rb[14:0], i_sdo};
		o_sync_n = 1'b1;
		// Line released: show the inverse rather than a stale level
		o_sdin   = ~o_sdin;
		repeat (8) @(negedge i_clock);
	endtask : xfer
endmodule : odcr_ctrl_model
`default_nettype wire

// file: testbench/odcr_tb_top.sv
/*
 Self-checking bench of the output driver configuration and readback block.
 Assumes the controller model drives the link; straps and faults are driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module odcr_tb_top;
	import odcr_pkg::*;
	logic           i_clock = 1'b0;
	logic           i_rst   = 1'b1;
	wire logic      i_sclk, i_sync_n, i_sdin;
	logic [2:0]     i_board_address_pins;
	logic [3:0]     i_range_pins;
	logic           i_control_mode_pin, i_sense_resistor_select_pin, i_clear_level_select_pin;
	logic           i_clear_pin, i_open_circuit, i_short_circuit, i_over_temp;
	odcr_range_type o_range, t;
	logic           o_sdo, o_sdo_oe, o_range_valid, o_current_drive_en, o_voltage_drive_en;
	logic           o_clear_active, o_clear_to_midscale, o_fault_n, o_fault_n_oe;
	logic           o_current_loop_fault_n, o_current_loop_fault_n_oe, o_voltage_short_fault_n;
	logic           o_voltage_short_fault_n_oe, o_temp_fault_n, o_temp_fault_n_oe;
	logic [4:0]     e_rng;
	logic           e_cls, e_en, e_swc, e_ifer, oe;
	logic [15:0]    rb;
	logic [11:0]    b;
	logic [31:0]    seed = 32'h4e99;
	logic [31:0]    r;
	int             n_fail = 0;
	int             n_checks = 0;

	always #10 i_clock = ~i_clock;

	odcr_top DUT (.i_clock, .i_rst, .i_sclk, .i_sync_n, .i_sdin, .o_sdo, .o_sdo_oe,
		.i_board_address_pins, .i_control_mode_pin, .i_range_pins,
		.i_sense_resistor_select_pin, .i_clear_level_select_pin, .i_clear_pin,
		.i_open_circuit, .i_short_circuit, .i_over_temp, .o_range, .o_range_valid,
		.o_current_drive_en, .o_voltage_drive_en, .o_clear_active, .o_clear_to_midscale,
		.o_fault_n, .o_fault_n_oe, .o_current_loop_fault_n, .o_current_loop_fault_n_oe,
		.o_voltage_short_fault_n, .o_voltage_short_fault_n_oe, .o_temp_fault_n,
		.o_temp_fault_n_oe);

	odcr_ctrl_model cm (.i_clock, .o_sclk(i_sclk), .o_sync_n(i_sync_n), .o_sdin(i_sdin),
		.i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic legal(input logic [4:0] c);
		odcr_range_type u;
		u     = u.first();
		legal = 1'b0;
		repeat (u.num()) begin
			if (u == c) legal = 1'b1;
			u = u.next();
		end
	endfunction : legal

	function automatic logic is_cur(input logic [4:0] c);
		return (c[3:2] == 2'h0 && c[1:0] != 2'h3) || c >= 5'h1d;
	endfunction : is_cur

	function automatic logic [15:0] word();
		return {i_board_address_pins, 2'h2, e_rng[3:0], e_cls, e_en, e_rng[4], e_ifer,
			i_over_temp, i_open_circuit, i_short_circuit};
	endfunction : word

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic chk_out();
		logic       v, c, m;
		logic [2:0] pf;
		v  = legal(e_rng);
		c  = is_cur(e_rng);
		m  = i_control_mode_pin;
		pf = {o_current_loop_fault_n_oe, o_voltage_short_fault_n_oe, o_temp_fault_n_oe};
		chk(o_range, e_rng, "range");
		chk(o_range_valid, v, "range valid");
		chk(16'({o_fault_n, o_current_loop_fault_n, o_voltage_short_fault_n, o_temp_fault_n}),
			16'h0000, "fault levels");
		chk(o_current_drive_en, (e_en | m) & v & c, "current enable");
		chk(o_voltage_drive_en, (e_en | m) & v & !c, "voltage enable");
		chk(o_fault_n_oe, !m & (i_open_circuit | i_short_circuit | i_over_temp | e_ifer),
			"fault");
		chk(pf, {3{m}} & {i_open_circuit, i_short_circuit, i_over_temp}, "pin faults");
		if (!m) begin
			chk(o_clear_active, i_clear_pin | e_swc, "clear");
			chk(o_clear_to_midscale, i_clear_level_select_pin | e_cls, "clear level");
		end
	endtask : chk_out

	task automatic rd_check(input logic exp_oe);
		cm.xfer({i_board_address_pins, 1'b1, 12'h000}, 20, 1'b0, 1'b0, rb, oe);
		chk(oe, exp_oe, "data out enable");
		if (exp_oe) chk(rb, word(), "readback");
		e_ifer = 1'b0;
		chk(o_sdo_oe, 1'b0, "data out release");
	endtask : rd_check

	task automatic wr(input logic [2:0] a, input logic ck, input logic bad, input int n);
		cm.xfer({a, 1'b0, b}, n, ck, bad, rb, oe);
	endtask : wr

	initial begin
		repeat (100000) @(posedge i_clock);
		n_fail++;
		$display("wrong value at %0t: run did not finish", $time);
		stop_test();
	end

	initial begin
		{i_board_address_pins, i_control_mode_pin, i_range_pins} = 8'h00;
		{i_sense_resistor_select_pin, i_clear_level_select_pin, i_clear_pin} = 3'h0;
		{i_open_circuit, i_short_circuit, i_over_temp} = 3'h0;
		{e_rng, e_cls, e_en, e_swc, e_ifer} = 9'h000;
		repeat (10) @(negedge i_clock);
		i_rst = 1'b0;
		r = rnd();
		i_board_address_pins = r[2:0];
		repeat (6) @(negedge i_clock);
		chk_out();
		rd_check(1'b1);
		$display("test reset done");
		// Every listed range code, with random fields, frame kind and faults
		t = t.first();
		for (int k = 0; k < t.num(); k++) begin
			r = rnd();
			e_rng = t;
			{e_swc, e_cls, e_en} = r[2:0];
			{i_clear_pin, i_clear_level_select_pin} = r[4:3];
			{i_open_circuit, i_short_circuit, i_over_temp} = r[7:5];
			b = {e_swc, e_rng[3:0], e_cls, e_en, e_rng[4], 1'b0, r[10:8]};
			wr(i_board_address_pins, r[11], 1'b0, r[11] ? 24 : 16);
			chk_out();
			rd_check(1'b1);
			t = t.next();
		end
		$display("test ranges done");
		b = {1'b0, 4'h5, 3'h7, 1'b0, 3'h0};
		wr(~i_board_address_pins, 1'b0, 1'b0, 16);
		chk_out();
		cm.xfer({~i_board_address_pins, 1'b1, 12'h000}, 20, 1'b0, 1'b0, rb, oe);
		chk(oe, 1'b0, "foreign read");
		wr(i_board_address_pins, 1'b0, 1'b0, 15);
		chk_out();
		wr(i_board_address_pins, 1'b1, 1'b1, 24);
		e_ifer = 1'b1;
		chk_out();
		rd_check(1'b1);
		chk_out();
		$display("test refusals done");
		b = {1'b1, 4'h6, 3'h7, 1'b1, 3'h0};
		wr(i_board_address_pins, 1'b0, 1'b0, 16);
		{e_rng, e_cls, e_en, e_swc, e_ifer} = 9'h000;
		chk_out();
		rd_check(1'b1);
		$display("test reset bit done");
		i_control_mode_pin = 1'b1;
		for (int k = 0; k < 8; k++) begin
			r = rnd();
			t = t.first();
			repeat (r[4:0] % 19) t = t.next();
			{i_sense_resistor_select_pin, i_range_pins} = t;
			e_rng = t;
			{i_open_circuit, i_short_circuit, i_over_temp} = r[7:5];
			repeat (8) @(negedge i_clock);
			chk_out();
		end
		// Unused code on the pins: neither drive enable may be set
		{i_sense_resistor_select_pin, i_range_pins} = 5'h03;
		e_rng = 5'h03;
		repeat (8) @(negedge i_clock);
		chk_out();
		rd_check(1'b0);
		$display("test pin mode done");
		stop_test();
	end
endmodule : odcr_tb_top
`default_nettype wire
